// ==== hw/mic_pkg.sv ====
// constants for the microcontroller interrupt controller
package mic_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int VEC_W = 12;
    localparam int NSRC = 5;
    localparam logic [7:0] CFG_ADDR = 8'hc8;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int BIT_LES = 6;
    localparam int BIT_ESB = 5;
    localparam int BIT_GEN = 4;
    localparam logic [11:0] VEC_SRC0 = 12'hffc;
    localparam logic [11:0] VEC_SRC1 = 12'hff6;
    localparam logic [11:0] VEC_SRC2 = 12'hff4;
    localparam logic [11:0] VEC_SRC3 = 12'hff2;
    localparam logic [11:0] VEC_SRC4 = 12'hff0;
    localparam int QUIRK_CYCLES = 3;
    localparam logic [1:0] QUIRK_CNT_W1 = 2'h1;
    localparam logic [2:0] FSET_NORMAL = 3'h1;
    localparam logic [2:0] FSET_SERVICE = 3'h2;
    localparam logic [2:0] FSET_NMI = 3'h4;
    typedef enum logic [1:0] {MIC_NORMAL, MIC_SERVICE, MIC_NMI} mic_mode_t;
endpackage

// ==== hw/mic_sync_edge.sv ====
// two-stage synchroniser with edge detection on the settled samples
`timescale 1ns/1ps
module mic_sync_edge #(
    parameter int W = 5
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o,
    output logic [W-1:0] fall_o,
    output logic [W-1:0] rise_o
);
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;

    // idle-high reset: lines are active low, so no false edge after reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta <= '1;
            sync <= '1;
            prev <= '1;
        end else begin
            meta <= async_i;
            sync <= meta;
            prev <= sync;
        end
    end

    // only the second stage and its delayed copy feed logic
    assign level_o = sync;
    assign fall_o = prev & ~sync;
    assign rise_o = ~prev & sync;
endmodule

// ==== hw/mic_core.sv ====
// interrupt controller: detection, priority, vectoring and flag sets
`timescale 1ns/1ps
module mic_core #(
    parameter int NEVT = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [mic_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [mic_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [mic_pkg::DATA_W-1:0] reg_rdata_o,
    // active-low request pins, source 0 to 4
    input wire logic [mic_pkg::NSRC-1:0] req_n_i,
    // peripheral events ORed onto source 4, active high, same clock
    input wire logic [NEVT-1:0] periph_evt_i,
    input wire logic [NEVT-1:0] periph_evt_clr_i,
    output logic [NEVT-1:0] periph_flag_o,
    // core handshake
    input wire logic instr_end_i,
    input wire logic return_from_service_i,
    input wire logic stop_wait_i,
    input wire logic [mic_pkg::VEC_W-1:0] pc_i,
    input wire logic carry_i,
    input wire logic zero_i,
    input wire logic flags_we_i,
    output logic take_o,
    output logic [mic_pkg::VEC_W-1:0] vector_o,
    output logic [mic_pkg::VEC_W-1:0] pc_push_o,
    output logic push_o,
    output logic pop_o,
    output logic [mic_pkg::NSRC-1:0] served_o,
    output logic carry_o,
    output logic zero_o,
    output logic [2:0] flag_set_o,
    output logic wake_o,
    output logic [1:0] mode_o
);
    logic [mic_pkg::DATA_W-1:0] cfg;
    mic_pkg::mic_mode_t mode;
    mic_pkg::mic_mode_t prev_mode;
    logic [mic_pkg::NSRC-1:0] lvl;
    logic [mic_pkg::NSRC-1:0] fall;
    logic [mic_pkg::NSRC-1:0] rise;
    logic nmi_latch;
    logic src1_latch;
    logic src2_latch;
    logic [NEVT-1:0] pflag;
    logic [1:0] quirk_cnt;
    logic swap_skipped;
    logic normal_carry_flag;
    logic normal_zero_flag;
    logic service_carry_flag;
    logic service_zero_flag;
    logic nmi_carry;
    logic nmi_zero;
    logic [mic_pkg::VEC_W-1:0] vector;
    logic [mic_pkg::NSRC-1:0] served;
    logic take_q;
    logic push_q;
    logic pop_q;
    logic [mic_pkg::VEC_W-1:0] pc_push;

    mic_sync_edge #(
        .W(mic_pkg::NSRC)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i(req_n_i),
        .level_o(lvl),
        .fall_o(fall),
        .rise_o(rise)
    );

    // option decode
    wire cfg_wr = reg_wr_i && (reg_addr_i == mic_pkg::CFG_ADDR);
    wire global_request_enable = cfg[mic_pkg::BIT_GEN];
    wire source1_level_edge_select = cfg[mic_pkg::BIT_LES];
    wire source2_edge_polarity = cfg[mic_pkg::BIT_ESB];
    wire gen_clear_wr = cfg_wr && !reg_wdata_i[mic_pkg::BIT_GEN];
    wire [mic_pkg::DATA_W-1:0] cfg_mask = (8'h1 << mic_pkg::BIT_LES)
        | (8'h1 << mic_pkg::BIT_ESB) | (8'h1 << mic_pkg::BIT_GEN);

    // source request terms
    wire src2_edge = source2_edge_polarity ? rise[2] : fall[2];
    wire evt_any = |pflag;
    wire req0 = nmi_latch;
    wire req1 = source1_level_edge_select ? !lvl[1] : src1_latch;
    wire req2 = src2_latch;
    wire req3 = !lvl[3];
    wire req4 = !lvl[4] || evt_any;
    wire [mic_pkg::NSRC-1:0] mreq = {req4, req3, req2, req1, 1'b0};

    // maskable allowed only from normal mode and with global enable
    wire mask_ok = global_request_enable && (mode == mic_pkg::MIC_NORMAL);
    wire nmi_ok = req0 && (mode != mic_pkg::MIC_NMI);
    wire [mic_pkg::NSRC-1:0] mgo = mask_ok ? mreq : '0;
    wire take = instr_end_i && (nmi_ok || (|mgo));

    // fixed priority pick: source 0, then 1 down to 4
    wire [mic_pkg::NSRC-1:0] win = nmi_ok ? 5'h01 :
        mgo[1] ? 5'h02 : mgo[2] ? 5'h04 : mgo[3] ? 5'h08 : mgo[4] ? 5'h10 : 5'h00;
    wire [mic_pkg::VEC_W-1:0] win_vec = win[0] ? mic_pkg::VEC_SRC0 :
        win[1] ? mic_pkg::VEC_SRC1 : win[2] ? mic_pkg::VEC_SRC2 :
        win[3] ? mic_pkg::VEC_SRC3 : mic_pkg::VEC_SRC4;

    // wake needs any request and the global enable, even for the nmi
    wire wake = stop_wait_i && global_request_enable && (req0 || (|mreq));

    // quirk: maskable entry within the early cycles of a clearing write
    wire quirk_hit = (quirk_cnt != 2'h0) || gen_clear_wr;

    // write-only option register, unused bits forced to zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg <= mic_pkg::CFG_RESET;
        end else if (cfg_wr) begin
            cfg <= reg_wdata_i & cfg_mask;
        end
    end

    // counts the remaining early cycles after a global-enable clearing write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            quirk_cnt <= 2'h0;
        end else if (gen_clear_wr) begin
            quirk_cnt <= 2'(mic_pkg::QUIRK_CYCLES - 1);
        end else if (quirk_cnt != 2'h0) begin
            quirk_cnt <= quirk_cnt - mic_pkg::QUIRK_CNT_W1;
        end
    end

    // latches: set wins over clear, one pending request only
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            nmi_latch <= 1'b0;
            src1_latch <= 1'b0;
            src2_latch <= 1'b0;
        end else begin
            nmi_latch <= fall[0] || (nmi_latch && !(take && win[0]));
            src1_latch <= (!source1_level_edge_select && fall[1])
                || (src1_latch && !(take && win[1]));
            src2_latch <= src2_edge || (src2_latch && !(take && win[2]));
        end
    end

    // per-event flags readable by software, event wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pflag <= '0;
        end else begin
            pflag <= periph_evt_i | (pflag & ~periph_evt_clr_i);
        end
    end

    // context: starts in nmi so init code is not interrupted
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode <= mic_pkg::MIC_NMI;
            prev_mode <= mic_pkg::MIC_NORMAL;
            swap_skipped <= 1'b0;
        end else if (take) begin
            mode <= win[0] ? mic_pkg::MIC_NMI : mic_pkg::MIC_SERVICE;
            prev_mode <= mode;
            swap_skipped <= !win[0] && quirk_hit;
        end else if (return_from_service_i) begin
            mode <= (mode == mic_pkg::MIC_NMI) ? prev_mode : mic_pkg::MIC_NORMAL;
            prev_mode <= mic_pkg::MIC_NORMAL;
            swap_skipped <= 1'b0;
        end
    end

    // flag set in use; quirk leaves the normal pair live in service mode
    wire use_nmi = (mode == mic_pkg::MIC_NMI);
    wire use_srv = (mode == mic_pkg::MIC_SERVICE) && !swap_skipped;

    // three separate carry/zero pairs, each written only while flag_set_o selects it
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            normal_carry_flag <= 1'b0;
            normal_zero_flag <= 1'b0;
            service_carry_flag <= 1'b0;
            service_zero_flag <= 1'b0;
            nmi_carry <= 1'b0;
            nmi_zero <= 1'b0;
        end else if (flags_we_i) begin
            if (use_nmi) begin
                nmi_carry <= carry_i;
                nmi_zero <= zero_i;
            end else if (use_srv) begin
                service_carry_flag <= carry_i;
                service_zero_flag <= zero_i;
            end else begin
                normal_carry_flag <= carry_i;
                normal_zero_flag <= zero_i;
            end
        end
    end

    // entry outputs: vector, push of pc, served strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            vector <= '0;
            served <= '0;
            take_q <= 1'b0;
            push_q <= 1'b0;
            pop_q <= 1'b0;
            pc_push <= '0;
        end else begin
            take_q <= take;
            push_q <= take;
            pop_q <= return_from_service_i && !take;
            served <= take ? win : '0;
            if (take) begin
                vector <= win_vec;
                pc_push <= pc_i;
            end
        end
    end

    // unmapped and write-only reads return zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= '0;
        end
    end

    assign take_o = take_q;
    assign push_o = push_q;
    assign pop_o = pop_q;
    assign vector_o = vector;
    assign pc_push_o = pc_push;
    assign served_o = served;
    assign periph_flag_o = pflag;
    assign wake_o = wake;
    assign mode_o = mode;
    assign carry_o = use_nmi ? nmi_carry : use_srv ? service_carry_flag : normal_carry_flag;
    assign zero_o = use_nmi ? nmi_zero : use_srv ? service_zero_flag : normal_zero_flag;
    assign flag_set_o = use_nmi ? mic_pkg::FSET_NMI : use_srv ? mic_pkg::FSET_SERVICE
        : mic_pkg::FSET_NORMAL;

    // sequences for the entry step
    sequence s_take;
        take;
    endsequence
    sequence s_entry;
        take_o && push_o;
    endsequence

    a_entry_push: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_take |=> s_entry) else $error("entry not followed by push");
    a_nmi_vector: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[0] |=> vector_o == mic_pkg::VEC_SRC0) else $error("bad nmi vector");
    a_src4_vector: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[4] |=> vector_o == mic_pkg::VEC_SRC4) else $error("bad src4 vector");
    a_no_nest: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mode != mic_pkg::MIC_NORMAL && take |-> win[0]) else $error("maskable nested");
    a_gen_mask: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !global_request_enable && take |-> win[0]) else $error("masked source taken");
    a_prio_order: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[2] |-> !mgo[1]) else $error("priority violated");
    a_nmi_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[0] && !fall[0] |=> !nmi_latch) else $error("nmi latch kept");
    a_wake_gen: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wake_o |-> global_request_enable) else $error("wake while disabled");
    a_reset_nmi: assert property (@(posedge clk_sys_i)
        $fell(rst_i) |-> mode == mic_pkg::MIC_NMI) else $error("reset mode wrong");
    a_ret_pop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        return_from_service_i && !take |=> pop_o) else $error("return without pop");

    // remaining vectors, each checked on its own winner
    a_src1_vector: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[1] |=> vector_o == mic_pkg::VEC_SRC1) else $error("bad src1 vector");
    a_src2_vector: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[2] |=> vector_o == mic_pkg::VEC_SRC2) else $error("bad src2 vector");
    a_src3_vector: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[3] |=> vector_o == mic_pkg::VEC_SRC3) else $error("bad src3 vector");

    // entry side effects follow the winner and pc of the previous edge; entry only on a boundary
    a_served_hot: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take |=> served_o == $past(win)) else $error("served strobe wrong");
    a_pc_saved: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take |=> pc_push_o == $past(pc_i)) else $error("pushed pc wrong");
    a_take_boundary: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take |-> instr_end_i) else $error("entry off boundary");

    // lower maskable sources only win when every higher maskable one is idle
    a_prio_src3: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[3] |-> !mgo[1] && !mgo[2]) else $error("src3 priority violated");
    a_prio_src4: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[4] |-> !(|mgo[3:1])) else $error("src4 priority violated");

    // detection: latches set from edges, level sources read live
    a_nmi_set: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fall[0] |=> nmi_latch) else $error("nmi edge lost");
    a_src1_latch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !source1_level_edge_select && fall[1] |=> src1_latch) else $error("src1 edge lost");
    a_one_pending: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        src2_latch && !(take && win[2]) |=> src2_latch) else $error("src2 request lost");
    a_lvl_live: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take && win[3] |-> !lvl[3]) else $error("src3 taken without level");
    a_edge_sync: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fall[1] |-> $past(lvl[1]) && !lvl[1]) else $error("edge not from samples");

    // flag sets, option bits and wake qualification
    a_nmi_flags: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mode == mic_pkg::MIC_NMI |-> flag_set_o == mic_pkg::FSET_NMI) else $error("nmi set off");
    a_quirk_keep: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        swap_skipped |-> flag_set_o != mic_pkg::FSET_SERVICE) else $error("quirk swapped");
    a_cfg_unused: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cfg & ~cfg_mask) == '0) else $error("unused option bit set");
    a_wake_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wake_o |-> stop_wait_i) else $error("wake outside stop");
endmodule

// ==== tb/mic_core_model.sv ====
// processor core model: instruction boundaries and program counter
`timescale 1ns/1ps
module mic_core_model #(
    parameter int CYC = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic take_i,
    input wire logic [mic_pkg::VEC_W-1:0] vector_i,
    output logic instr_end_o,
    output logic [mic_pkg::VEC_W-1:0] pc_o
);
    logic [3:0] cnt;
    // every instruction lasts CYC cycles; the boundary strobe is one cycle
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt <= 4'h0;
            instr_end_o <= 1'b0;
            pc_o <= 12'h000;
        end else begin
            cnt <= (cnt == 4'(CYC - 1)) ? 4'h0 : cnt + 4'h1;
            instr_end_o <= (cnt == 4'(CYC - 2));
            // entry jumps to the vector, so the skipped instruction never runs
            if (take_i) begin
                pc_o <= vector_i;
            end else if (instr_end_o) begin
                pc_o <= pc_o + 12'h001;
            end
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ret = 1'b0;
    logic stop_wait = 1'b0, carry = 1'b0, zero = 1'b0, flags_we = 1'b0, rd_seen = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
    logic [4:0] req_n = 5'h1f, served;
    logic [3:0] evt = 4'h0, evt_clr = 4'h0, flag;
    logic instr_end, take, push, pop, carry_o, zero_o, wake;
    logic [11:0] pc, vector, pc_push;
    logic [2:0] flag_set;
    logic [1:0] mode;
    logic [11:0] exp_vec[$], exp_rd[$];
    logic [11:0] ev, pc_last = 12'h000;
    logic [4:0] es;
    logic [11:0] vt[5] = '{mic_pkg::VEC_SRC0, mic_pkg::VEC_SRC1, mic_pkg::VEC_SRC2,
                           mic_pkg::VEC_SRC3, mic_pkg::VEC_SRC4};
    int n_mismatch = 0, n_compared = 0, n_take = 0, k;
    always #4 clk_sys_i = ~clk_sys_i;
    mic_core u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .req_n_i(req_n), .periph_evt_i(evt), .periph_evt_clr_i(evt_clr),
        .periph_flag_o(flag), .instr_end_i(instr_end), .return_from_service_i(ret),
        .stop_wait_i(stop_wait), .pc_i(pc), .carry_i(carry), .zero_i(zero),
        .flags_we_i(flags_we), .take_o(take), .vector_o(vector), .pc_push_o(pc_push),
        .push_o(push), .pop_o(pop), .served_o(served), .carry_o(carry_o), .zero_o(zero_o),
        .flag_set_o(flag_set), .wake_o(wake), .mode_o(mode));
    mic_core_model u_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .take_i(take),
        .vector_i(vector), .instr_end_o(instr_end), .pc_o(pc));
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // results are checked against the oldest note as they appear
    always @(posedge clk_sys_i) begin
        if (rd_seen) chk("rdata", rdata, exp_rd.pop_front());
        rd_seen <= reg_rd;
        pc_last <= pc;
        if (take === 1'b1) begin
            n_take++;
            chk("push", 12'(push), 12'h1);
            if (exp_vec.size() == 0) chk("unexpected take", 12'h1, 12'h0);
            else begin
                ev = exp_vec.pop_front();
                es = 5'h00;
                for (int i = 0; i < 5; i++) if (vt[i] == ev) es = 5'(1 << i);
                chk("vector", vector, ev);
                chk("served", 12'(served), 12'(es));
                chk("pc pushed", pc_push, pc_last);
            end
        end
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys_i) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i) {reg_addr, reg_rd} <= {a, 1'b1};
        exp_rd.push_back(12'h0);
        @(posedge clk_sys_i) reg_rd <= 1'b0;
    endtask
    task automatic ret_pulse();
        @(posedge clk_sys_i) ret <= 1'b1;
        @(posedge clk_sys_i) ret <= 1'b0;
        #1 chk("pop", 12'(pop), 12'h1);
    endtask
    // bounded wait for the next entry seen by the monitor
    task automatic wait_take();
        int t0;
        t0 = n_take;
        repeat (60) begin
            @(posedge clk_sys_i);
            if (n_take != t0) break;
        end
        #1 chk("take seen", 12'(n_take != t0), 12'h1);
    endtask
    task automatic pulse(input int s);
        @(posedge clk_sys_i) req_n[s] <= 1'b0;
        idle(3);
        @(posedge clk_sys_i) req_n[s] <= 1'b1;
    endtask
    initial begin
        #100000 n_mismatch++;
        final_report();
    end
    initial begin
        void'($urandom(32'he8e6d132));
        idle(4);
        rst_i <= 1'b0;
        idle(2);
        chk("reset mode", mode, 12'h2);
        rd(mic_pkg::CFG_ADDR);
        rd(8'h00 + 8'($urandom_range(0, 8'hc7)));
        wr(mic_pkg::CFG_ADDR, 8'h50);
        idle(12);
        chk("mode held in nmi", mode, 12'h2);
        ret_pulse();
        idle(2);
        chk("mode normal", mode, 12'h0);
        @(posedge clk_sys_i) {carry, zero, flags_we} <= 3'b111;
        @(posedge clk_sys_i) flags_we <= 1'b0;
        // each of sources 1 to 4 alone, source 2 by its falling edge; requester holds low until entry
        for (int s = 1; s < 5; s++) begin
            @(posedge clk_sys_i) {req_n[s], stop_wait} <= 2'b01;
            exp_vec.push_back(vt[s]);
            wait_take();
            chk("mode service", mode, 12'h1);
            chk("flag set service", flag_set, 12'(mic_pkg::FSET_SERVICE));
            chk("wake", wake, 12'(s != 2));
            chk("service carry", carry_o, 12'h0);
            @(posedge clk_sys_i) {req_n[s], stop_wait} <= 2'b10;
            idle(4);
            ret_pulse();
            idle(3);
            chk("carry restored", carry_o, 12'h1);
            chk("zero restored", zero_o, 12'h1);
        end
        // three levels at once, served one by one in fixed order
        exp_vec = '{vt[1], vt[3], vt[4]};
        @(posedge clk_sys_i) req_n <= 5'b00101;
        wait_take();
        @(posedge clk_sys_i) req_n[1] <= 1'b1;
        idle(12);
        ret_pulse();
        wait_take();
        @(posedge clk_sys_i) req_n[3] <= 1'b1;
        ret_pulse();
        wait_take();
        @(posedge clk_sys_i) req_n[4] <= 1'b1;
        // two falling edges during a routine leave one stored request
        pulse(2);
        pulse(2);
        exp_vec.push_back(vt[2]);
        idle(8);
        ret_pulse();
        wait_take();
        // non-maskable preempts the running routine, latch cleared on entry
        @(posedge clk_sys_i) req_n[0] <= 1'b0;
        exp_vec.push_back(vt[0]);
        wait_take();
        chk("mode nmi", mode, 12'h2);
        chk("flag set nmi", flag_set, 12'(mic_pkg::FSET_NMI));
        @(posedge clk_sys_i) req_n[0] <= 1'b1;
        ret_pulse();
        idle(2);
        chk("back to service", mode, 12'h1);
        ret_pulse();
        idle(16);
        chk("back to normal", mode, 12'h0);
        // source 1 in falling-edge mode: a held low gives one entry
        wr(mic_pkg::CFG_ADDR, 8'h10);
        @(posedge clk_sys_i) req_n[1] <= 1'b0;
        exp_vec.push_back(vt[1]);
        wait_take();
        idle(4);
        ret_pulse();
        idle(20);
        @(posedge clk_sys_i) req_n[1] <= 1'b1;
        // rising polarity on source 2: only the release edge counts
        wr(mic_pkg::CFG_ADDR, 8'h30);
        exp_vec.push_back(vt[2]);
        pulse(2);
        wait_take();
        ret_pulse();
        idle(8);
        // global enable clear: maskable blocked, nmi served, no wake
        wr(mic_pkg::CFG_ADDR, 8'h00);
        @(posedge clk_sys_i) {req_n[3], stop_wait} <= 2'b01;
        idle(4);
        chk("wake masked", wake, 12'h0);
        @(posedge clk_sys_i) req_n[0] <= 1'b0;
        exp_vec.push_back(vt[0]);
        wait_take();
        @(posedge clk_sys_i) req_n[0] <= 1'b1;
        ret_pulse();
        idle(20);
        chk("masked stays normal", mode, 12'h0);
        @(posedge clk_sys_i) {req_n[3], stop_wait} <= 2'b10;
        // one random event keeps its own flag until cleared
        k = $urandom_range(0, 3);
        @(posedge clk_sys_i) evt[k] <= 1'b1;
        @(posedge clk_sys_i) evt[k] <= 1'b0;
        idle(2);
        chk("event flag", flag, 12'(4'h1 << k));
        @(posedge clk_sys_i) evt_clr <= 4'hf;
        @(posedge clk_sys_i) evt_clr <= 4'h0;
        idle(2);
        chk("event flag cleared", flag, 12'h0);
        final_report();
    end
endmodule
